//--- bench/core_model.sv
// Purpose: Core side: grants a request, moves one byte
// Assumes: One transfer at a time
// Notes:   Done comes 21 cycles after grant, slower than any move
`timescale 1ns/1ns
`default_nettype none
module core_model
  import xfer_chan_pkg::*;
(
  // Clock, reset and count preload
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        load_in,
  input  wire logic [15:0] count_in,
  // Channel side
  input  wire xfer_req_s   req_in,
  output var  xfer_rsp_s   rsp_out
);
  logic        busy_q;
  logic [4:0]  wait_q;
  logic [15:0] left_q;
  always_ff @(posedge clk_sys_in) begin
    rsp_out.grant <= 1'b0;
    rsp_out.done <= 1'b0;
    if (!rst_b_in) begin
      busy_q <= 1'b0;
      wait_q <= 5'h00;
      rsp_out.count_after <= 16'h0000;
    end else if (load_in) begin
      left_q <= count_in;
    end else if (!busy_q && req_in.req) begin
      rsp_out.grant <= 1'b1;
      busy_q <= 1'b1;
      wait_q <= 5'h14;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      rsp_out.done <= 1'b1;
      left_q <= left_q - 16'h0001;
      rsp_out.count_after <= left_q - 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- bench/xfer_chan_bench.sv
// Purpose: Directed register and transfer checks of the channel
// Assumes: Cleared register resets, as the design chose
// Notes:   Top level busy and wait states are held low
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
`define WAITF(c) begin wk = 0; while ((c) !== 1'b1 && wk < 400) begin \
  @(negedge clk_sys_in); wk++; end if (wk >= 400) begin n_fail++; \
  complete_run; end end
module xfer_chan_bench
  import xfer_chan_pkg::*;
;
  logic        clk_sys_in, rst_b_in, cyc, stb, we, trig, load, ack, irq;
  logic        busy;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [2:0]  cur, prio;
  logic [7:0]  q;
  xfer_req_s   req;
  xfer_rsp_s   rsp;
  int          n_fail, checks_done, wk;
  xfer_chan DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .trigger_in(trig), .current_priority_level_in(cur),
    .top_level_busy_in(1'b0), .wait_state_in(1'b0), .core_rsp_in(rsp),
    .core_req_out(req), .req_priority_out(prio), .eob_irq_out(irq),
    .xfer_busy_out(busy));
  core_model u_core (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .load_in(load), .count_in(16'h0001), .req_in(req), .rsp_out(rsp));
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int k;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 9);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK(k < 9, 1'b1)
    if (k >= 9) begin
      complete_run;
    end
  endtask
  // Preload one byte in the core, then one trigger cycle
  task automatic start;
    load <= 1'b1;
    @(posedge clk_sys_in);
    load <= 1'b0;
    trig <= 1'b1;
    @(posedge clk_sys_in);
    trig <= 1'b0;
  endtask
  initial begin
    {rst_b_in, cyc, stb, we, trig, load, adr, wdat, cur} = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4), 8'h00);
      `CHK(q, 8'h00)
    end
    bus(1'b0, 4'h2, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, 4'h4, 8'hFF);
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q, 8'h3F)
    `CHK(req.req, 1'b0)
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, 4'h0, 8'h21);
    bus(1'b1, 4'h8, 8'h35);
    bus(1'b1, 4'h4, 8'h18);
    start;
    `WAITF(req.req)
    `CHK(req.cnt_addr, 8'h20)
    `CHK(req.adr_addr, 8'h34)
    `CHK({req.is_file, req.seg_sel}, 2'b10)
    `WAITF(irq)
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q, 8'h08)
    bus(1'b1, 4'hC, 8'h01);
    bus(1'b1, 4'h0, 8'h20);
    bus(1'b1, 4'h4, 8'h18);
    start;
    `WAITF(req.req)
    `CHK({req.is_file, req.seg_sel}, 2'b01)
    `WAITF(irq)
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q, 8'h18)
    bus(1'b0, 4'hC, 8'h00);
    `CHK(q, 8'h03)
    bus(1'b1, 4'hC, 8'h00);
    bus(1'b1, 4'h4, 8'h28);
    repeat (3) @(negedge clk_sys_in);
    `CHK({irq, req.req}, 2'b10)
    @(posedge clk_sys_in);
    cur <= 3'h2;
    bus(1'b1, 4'h4, 8'h33);
    repeat (4) @(negedge clk_sys_in);
    `CHK(req.req, 1'b0)
    @(posedge clk_sys_in);
    cur <= 3'h3;
    `WAITF(req.req)
    `CHK(irq, 1'b0)
    `WAITF(busy)
    `WAITF(!busy)
    bus(1'b0, 4'h4, 8'h00);
    `CHK(q, 8'h13)
    complete_run;
  end
endmodule
`default_nettype wire

//--- bench/xfer_chan_props.sv
// Purpose: Port checks of the transfer channel
// Assumes: Core model answers each grant within 22 cycles
// Notes:   Bound to every channel instance
`timescale 1ns/1ns
`default_nettype none
module xfer_chan_props
  import xfer_chan_pkg::*;
(
  // Watched ports
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [2:0]  current_priority_level_in,
  input wire xfer_rsp_s   core_rsp_in,
  input wire xfer_req_s   core_req_out,
  input wire logic [2:0]  req_priority_out,
  input wire logic        eob_irq_out,
  input wire logic        xfer_busy_out
);
  wire g = core_req_out.req && core_rsp_in.grant;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_ack_next:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  a_upper_zero:
    assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_even_ptr:
    assert property (core_req_out.req |->
      !core_req_out.cnt_addr[0] && !core_req_out.adr_addr[0])
    else $error("odd pointer");
  a_file_seg:
    assert property (core_req_out.req && core_req_out.is_file |->
      !core_req_out.seg_sel) else $error("segment used in file mode");
  a_prio_ok:
    assert property (core_req_out.req |->
      req_priority_out <= current_priority_level_in)
    else $error("request below priority");
  a_one_xfer: assert property (xfer_busy_out |-> !core_req_out.req)
    else $error("request while busy");
  a_file_time:
    assert property (g && core_req_out.is_file |-> ##2 xfer_busy_out[*7])
    else $error("file move short");
  a_mem_time:
    assert property (g && !core_req_out.is_file |-> ##9 xfer_busy_out[*8])
    else $error("memory move short");
  c_file: cover property (g && core_req_out.is_file);
  c_mem: cover property (g && !core_req_out.is_file);
  c_eob: cover property ($rose(eob_irq_out));
endmodule
bind xfer_chan xfer_chan_props u_props (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .current_priority_level_in(current_priority_level_in),
  .core_rsp_in(core_rsp_in), .core_req_out(core_req_out),
  .req_priority_out(req_priority_out), .eob_irq_out(eob_irq_out),
  .xfer_busy_out(xfer_busy_out));
`default_nettype wire

//--- design/xfer_chan.sv
// Purpose: Control of one peripheral transfer channel with Wishbone registers
// Assumes: Core performs the byte move and reports counter value after it
// Notes:   Control and status word bits line up with the channel control reg
//          Pointers only feed the core; the channel never reaches the file
//          Register resets are cleared, yet software must still load them
//          Move lengths are parameters; the check below bounds them
//
// Functional notes
// - Pointer bit 0: 1 file, 0 memory
// - Trigger event sets pending flag
// - Core acknowledge clears pending flag
// - Software may set or clear pending
// - Counter zero clears request mask, unless swap
// - Transfer request only when mask set
// - Interrupt when end-block mask and pending
// - Mask 1, eob 0: request, no interrupt
// - Mask 0, eob 1: interrupt only
// - Priority 0 highest, 7 lowest
// - Address bit 0 selects segment register
// - Segment select ignored for file transfers
// - One byte moved, address up, count down
// - Execute when priority at least current
// - File 8 cycles, memory 16 plus waits
// - Swap: alternate table, mask kept, interrupt
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "xfer_chan_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module xfer_chan
  import xfer_chan_pkg::*;
#(
  // Transfer durations in processor clock cycles
  parameter int unsigned FILE_CYC = `CYC_FILE_XFER,
  parameter int unsigned MEM_CYC  = `CYC_MEM_XFER
)
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Peripheral and core side
  input  wire logic        trigger_in,
  input  wire logic [2:0]  current_priority_level_in,
  input  wire logic        top_level_busy_in,
  input  wire logic        wait_state_in,
  input  wire xfer_rsp_s   core_rsp_in,
  output xfer_req_s        core_req_out,
  output logic      [2:0]  req_priority_out,
  output logic             eob_irq_out,
  output logic             xfer_busy_out
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Move counter is five bits; a zero length would wrap to a 32-cycle move
  if (FILE_CYC < 1 || FILE_CYC > 32) begin : g_bad_file_cyc
    $error("file transfer length out of range");
  end
  if (MEM_CYC < 1 || MEM_CYC > 32) begin : g_bad_mem_cyc
    $error("memory transfer length out of range");
  end

  // ---------------------------------------------------------------
  // Registered state
  // ---------------------------------------------------------------
  // One word, so the reset reaches every field
  typedef struct packed {
    // Software registers
    logic [7:0]  counter_pointer_reg;
    logic [7:0]  channel_control_reg;
    logic [7:0]  address_pointer_reg;
    // Swap control
    logic        swap_en;
    logic        table_sel;
    // Sequence
    chan_state_e state;
    logic [4:0]  cycles;
    logic        busy;
    // Bus answer
    logic [31:0] rdata;
    logic        ack;
    // Core side
    xfer_req_s   req;
    logic        eob_irq;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane write of the low byte
  function automatic logic [7:0] lane0(input logic [7:0] old_v,
                                       input logic [3:0] sel,
                                       input logic [31:0] dat);
    lane0 = sel[0] ? dat[7:0] : old_v;
  endfunction

  // Pointer as even register-file address
  function automatic logic [7:0] even_addr(input logic [7:0] p);
    even_addr = {p[7:1], 1'b0};
  endfunction

  // Control byte: bits 7:6 always read back as zero
  function automatic logic [7:0] ctrl_write(input logic [7:0] old_v,
                                            input logic [3:0] sel,
                                            input logic [31:0] dat);
    logic [7:0] v;
    v = lane0(old_v, sel, dat);
    ctrl_write = {2'b00, v[5:0]};
  endfunction

  // Last count of a move; memory moves are the longer kind
  function automatic logic [4:0] last_cycle(input logic file_sel);
    last_cycle = file_sel ? 5'(FILE_CYC - 1) : 5'(MEM_CYC - 1);
  endfunction

  // Eight-bit register on lane 0, upper lanes read zero
  function automatic logic [31:0] rd_word(input logic [7:0] v);
    rd_word = {24'h000000, v};
  endfunction

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  // Decoded bus and control fields
  logic wr_hit;
  logic rd_hit;
  logic pend;
  logic rmask;
  logic emask;
  logic [2:0] source_priority_level;
  logic is_file;
  logic prio_ok;
  logic stall;

  always_comb begin
    wr_hit  = wb_cyc_in && wb_stb_in && wb_we_in && !s_q.ack;
    rd_hit  = wb_cyc_in && wb_stb_in && !wb_we_in && !s_q.ack;
    pend    = s_q.channel_control_reg[`BIT_PENDING];
    rmask   = s_q.channel_control_reg[`BIT_REQ_MASK];
    emask   = s_q.channel_control_reg[`BIT_EOB_MASK];
    source_priority_level     = s_q.channel_control_reg[2:0];
    is_file = s_q.counter_pointer_reg[`BIT_SELECT];
    // Lower code is higher priority; equal accepted
    // Top level service in progress blocks every request
    prio_ok = (source_priority_level <= current_priority_level_in) && !top_level_busy_in;
    // Wait states only stretch memory moves; file moves are fixed
    stall   = wait_state_in && !is_file;
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.rdata = 32'h0000_0000;
    s_d.req.req = 1'b0;

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    // Unmapped offsets read zero and are still acked
    if (wr_hit || rd_hit) begin
      s_d.ack = 1'b1;
    end
    if (rd_hit) begin
      case (wb_adr_in)
        `OFS_COUNTER_PTR: s_d.rdata = rd_word(s_q.counter_pointer_reg);
        `OFS_CHAN_CTRL:   s_d.rdata = rd_word(s_q.channel_control_reg);
        `OFS_ADDR_PTR:    s_d.rdata = rd_word(s_q.address_pointer_reg);
        // Config word: bit 2 not idle, bit 1 table, bit 0 swap
        `OFS_CONFIG:      s_d.rdata = {29'h0000000, s_q.state != ST_IDLE,
                                       s_q.table_sel, s_q.swap_en};
        default:          s_d.rdata = 32'h0000_0000;
      endcase
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    if (wr_hit) begin
      case (wb_adr_in)
        `OFS_COUNTER_PTR: s_d.counter_pointer_reg =
            lane0(s_q.counter_pointer_reg, wb_sel_in, wb_dat_in);
        // Software write sets or cancels pending
        `OFS_CHAN_CTRL:   s_d.channel_control_reg =
            ctrl_write(s_q.channel_control_reg, wb_sel_in, wb_dat_in);
        `OFS_ADDR_PTR:    s_d.address_pointer_reg =
            lane0(s_q.address_pointer_reg, wb_sel_in, wb_dat_in);
        // Table select writable so software picks the start table
        `OFS_CONFIG:      if (wb_sel_in[0]) begin
          s_d.swap_en   = wb_dat_in[`BIT_SWAP_EN];
          s_d.table_sel = wb_dat_in[1];
        end
        // Unmapped writes are dropped
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Channel sequence
    // ---------------------------------------------------------------
    // Idle waits for pending and mask, the grant wait offers the request,
    // the move counts the core's cycles, and the finish waits for the
    // core's done together with its count after the move
    s_d.eob_irq = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        if (pend && rmask) begin
          s_d.state = ST_WAIT_GRANT;
        end
      end
      ST_WAIT_GRANT: begin
        // Withdraw when software cancels pending or mask
        if (!pend || !rmask) begin
          s_d.state = ST_IDLE;
        end else if (prio_ok) begin
          // Request stands each cycle until the core grants
          s_d.req.req = 1'b1;
          s_d.req.is_file = is_file;
          s_d.req.seg_sel = is_file ? 1'b0 :
                            s_q.address_pointer_reg[`BIT_SELECT];
          s_d.req.cnt_addr  = even_addr(s_q.counter_pointer_reg);
          s_d.req.adr_addr  = even_addr(s_q.address_pointer_reg);
          s_d.req.table_sel = s_q.table_sel;
          if (core_rsp_in.grant) begin
            s_d.req.req = 1'b0;
            s_d.channel_control_reg[`BIT_PENDING] = 1'b0;
            s_d.cycles = 5'h00;
            s_d.state = ST_MOVE;
          end
        end
      end
      ST_MOVE: begin
        // Duration per target; waits stretch memory
        if (!stall) begin
          s_d.cycles = s_q.cycles + 5'h01;
        end
        if (s_q.cycles == last_cycle(is_file) && !stall) begin
          s_d.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        // Core reports count after its byte move
        if (core_rsp_in.done) begin
          s_d.state = ST_IDLE;
          // Count of zero marks the end of block
          if (core_rsp_in.count_after == 16'h0000) begin
            // Swap keeps mask, flips table
            // Tables keep alternating until swap is disabled
            if (s_q.swap_en) begin
              s_d.table_sel = !s_q.table_sel;
            end else begin
              s_d.channel_control_reg[`BIT_REQ_MASK] = 1'b0;
            end
            s_d.eob_irq = emask;
          end
        end
      end
      default: s_d.state = ST_IDLE;
    endcase

    // Pending with eob mask but no request mask
    if (pend && emask && !rmask) begin
      s_d.eob_irq = 1'b1;
    end

    // Trigger wins over any clear
    // Sampled every clock; a held trigger keeps pending set
    if (trigger_in) begin
      s_d.channel_control_reg[`BIT_PENDING] = 1'b1;
    end

    // Busy follows the next state so the output stands registered
    s_d.busy = (s_d.state == ST_MOVE) || (s_d.state == ST_FINISH);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Synchronous reset clears every field
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.counter_pointer_reg <= `RST_PTR;
      s_q.address_pointer_reg <= `RST_PTR;
      s_q.channel_control_reg <= `RST_CTRL;
      s_q.state <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a field of the state register
  always_comb begin
    wb_dat_out       = s_q.rdata;
    wb_ack_out       = s_q.ack;
    core_req_out     = s_q.req;
    req_priority_out = s_q.channel_control_reg[2:0];
    eob_irq_out      = s_q.eob_irq;
    xfer_busy_out    = s_q.busy;
  end

endmodule

`default_nettype wire

//--- include/xfer_chan_pkg.sv
// Purpose: Types shared by the transfer channel
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Constants live in xfer_chan_regs.svh
package xfer_chan_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_GRANT,
    ST_MOVE,
    ST_FINISH
  } chan_state_e;

  // Register-file access towards the core
  typedef struct packed {
    logic       req;
    logic       is_file;
    logic       seg_sel;
    logic [7:0] cnt_addr;
    logic [7:0] adr_addr;
    logic       table_sel;
  } xfer_req_s;

  // Grant and completion of one byte move reported by the core
  typedef struct packed {
    logic       grant;
    logic       done;
    logic [15:0] count_after;
  } xfer_rsp_s;

endpackage

//--- include/xfer_chan_regs.svh
// Purpose: Offsets, field positions and timing counts of the transfer channel
// Assumes: Word-aligned 32-bit Wishbone register map
// Notes:   Definitions only
`ifndef XFER_CHAN_REGS_SVH
`define XFER_CHAN_REGS_SVH

// Register byte offsets
`define OFS_COUNTER_PTR   4'h0
`define OFS_CHAN_CTRL     4'h4
`define OFS_ADDR_PTR      4'h8
`define OFS_CONFIG        4'hC

// Field positions
`define BIT_SELECT        0
`define BIT_PENDING       5
`define BIT_REQ_MASK      4
`define BIT_EOB_MASK      3
`define BIT_SWAP_EN       0

// Reset values (documented undefined; cleared here)
`define RST_PTR           8'h00
`define RST_CTRL          8'h00

// Transfer durations in processor clock cycles
`define CYC_FILE_XFER     8
`define CYC_MEM_XFER      16

`endif
